/* rtl/iocs_clock_switch.sv */
// glitch-free switch of the system clock between three internal oscillators
`timescale 1ns/10ps
//
// Overview of operation
// - A write that changes the four-bit frequency select field starts a new selection sequence.
// - If the chosen oscillator is stopped, it is started and its start-up delay is waited out.
// - With the new oscillator ready, the switch waits for a falling edge of the current clock.
// - After that falling edge the system clock is held low until the new oscillator rises after a falling edge of its own.
// - On that rising edge the new oscillator becomes the active system clock source.
// - Only after the new clock is active is the status register updated and the switch done.
// - The status register shows for each of the three oscillators whether it is active.
// - A change between two selections of the same source takes effect with no start-up delay.
module iocs_clock_switch
  import iocs_pkg::*;
#(
  parameter int STARTUP_CYCLES = IOCS_STARTUP_CYCLES
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // oscillators: bit 0 low, bit 1 mid, bit 2 high
  input  wire logic [2:0]  osc_clk_in,
  input  wire logic [2:0]  osc_ready_in,
  output logic      [2:0]  osc_enable,
  output logic      [3:0]  freq_select_out,
  // switched system clock
  output logic             sys_clk_out
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STARTUP_CYCLES - 1);

  // pins from the oscillators are asynchronous to core_clk
  logic [2:0] clk_meta;
  logic [2:0] clk_sync;
  logic [2:0] clk_prev;
  logic [2:0] rdy_meta;
  logic [2:0] rdy_sync;

  iocs_state_t state;
  iocs_state_t next_state;
  logic [1:0]    cur_src;
  logic [1:0]    next_cur_src;
  logic [1:0]    new_src;
  logic [1:0]    next_new_src;
  logic [3:0]    ctrl_sel;
  logic [3:0]    next_ctrl_sel;
  logic [3:0]    tgt_sel;
  logic [3:0]    next_tgt_sel;
  logic [3:0]    next_freq_select;
  logic [2:0]    status;
  logic [2:0]    next_status;
  logic [2:0]    next_osc_enable;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          new_fall_seen;
  logic          next_new_fall_seen;
  logic          next_sys_clk;
  logic          next_ack;
  logic [31:0]   next_dat;

  logic [2:0] rise;
  logic [2:0] fall;
  logic [1:0] sel_src;

  function automatic logic [1:0] src_of(input logic [3:0] sel);
    logic [1:0] s;
    s = IOCS_SRC_LF;
    if (sel >= IOCS_SEL_HF_FIRST)
      s = IOCS_SRC_HF;
    else if (sel >= IOCS_SEL_MF_FIRST)
      s = IOCS_SRC_MF;
    return s;
  endfunction

  function automatic logic [2:0] onehot(input logic [1:0] s);
    return 3'(3'h1 << s);
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clk_meta <= 3'h0;
      clk_sync <= 3'h0;
      clk_prev <= 3'h0;
      rdy_meta <= 3'h0;
      rdy_sync <= 3'h0;
    end
    else
    begin
      clk_meta <= osc_clk_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      rdy_meta <= osc_ready_in;
      rdy_sync <= rdy_meta;
    end
  end

  assign rise    = clk_sync & ~clk_prev;
  assign fall    = ~clk_sync & clk_prev;
  assign sel_src = src_of(ctrl_sel);

  always_comb
  begin
    next_state         = state;
    next_cur_src       = cur_src;
    next_new_src       = new_src;
    next_ctrl_sel      = ctrl_sel;
    next_tgt_sel       = tgt_sel;
    next_freq_select   = freq_select_out;
    next_status        = status;
    next_osc_enable    = osc_enable;
    next_cnt           = cnt;
    next_new_fall_seen = new_fall_seen;
    next_sys_clk       = clk_sync[cur_src];
    // single-cycle ack; unmapped offsets read zero and ignore writes
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = 32'h0;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      if (wb_we_i && wb_adr_i == IOCS_CTRL_OFF && wb_sel_i[0])
        next_ctrl_sel = wb_dat_i[IOCS_SEL_MSB:0];
      if (!wb_we_i && wb_adr_i == IOCS_CTRL_OFF)
        next_dat = {28'h0, ctrl_sel};
      if (!wb_we_i && wb_adr_i == IOCS_STAT_OFF)
      begin
        next_dat[IOCS_STAT_HF:IOCS_STAT_LF] = status;
        next_dat[IOCS_STAT_BUSY]            = (state != IOCS_IDLE);
      end
    end
    unique case (state)
      IOCS_IDLE:
      begin
        // a write of the same code starts nothing
        if (ctrl_sel != freq_select_out)
        begin
          if (sel_src == cur_src)
            next_freq_select = ctrl_sel;
          else
          begin
            // code latched here; later writes wait for the next round
            next_tgt_sel = ctrl_sel;
            next_new_src = sel_src;
            next_osc_enable[sel_src] = 1'b1;
            next_cnt = '0;
            if (osc_enable[sel_src] && rdy_sync[sel_src])
              next_state = IOCS_WAIT_FALL;
            else
              next_state = IOCS_START;
          end
        end
      end
      IOCS_START:
      begin
        // count only once the oscillator reports ready
        if (rdy_sync[new_src])
        begin
          if (cnt == CNT_LAST)
            next_state = IOCS_WAIT_FALL;
          else
            next_cnt = cnt + CW'(1);
        end
      end
      IOCS_WAIT_FALL:
      begin
        if (fall[cur_src])
        begin
          next_state         = IOCS_HOLD_LOW;
          next_new_fall_seen = 1'b0;
          next_sys_clk       = 1'b0;
        end
      end
      IOCS_HOLD_LOW:
      begin
        next_sys_clk = 1'b0;
        // a full low phase of the new clock keeps the output low phase honest
        if (fall[new_src])
          next_new_fall_seen = 1'b1;
        if (new_fall_seen && rise[new_src])
        begin
          next_cur_src     = new_src;
          next_sys_clk     = 1'b1;
          next_freq_select = tgt_sel;
          next_state       = IOCS_UPDATE;
        end
      end
      IOCS_UPDATE:
      begin
        // old oscillator is stopped only after the handover
        next_status     = onehot(cur_src);
        next_osc_enable = onehot(cur_src);
        next_state      = IOCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state           <= IOCS_IDLE;
      cur_src         <= IOCS_SRC_LF;
      new_src         <= IOCS_SRC_LF;
      ctrl_sel        <= IOCS_SEL_RESET;
      tgt_sel         <= IOCS_SEL_RESET;
      freq_select_out <= IOCS_SEL_RESET;
      status          <= IOCS_OSC_RESET;
      osc_enable      <= IOCS_OSC_RESET;
      cnt             <= '0;
      new_fall_seen   <= 1'b0;
      sys_clk_out     <= 1'b0;
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h0;
    end
    else
    begin
      state           <= next_state;
      cur_src         <= next_cur_src;
      new_src         <= next_new_src;
      ctrl_sel        <= next_ctrl_sel;
      tgt_sel         <= next_tgt_sel;
      freq_select_out <= next_freq_select;
      status          <= next_status;
      osc_enable      <= next_osc_enable;
      cnt             <= next_cnt;
      new_fall_seen   <= next_new_fall_seen;
      sys_clk_out     <= next_sys_clk;
      wb_ack_o        <= next_ack;
      wb_dat_o        <= next_dat;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_change_pending;
    state == IOCS_IDLE && ctrl_sel != freq_select_out;
  endsequence

  sequence s_handover;
    state == IOCS_HOLD_LOW ##1 state == IOCS_UPDATE;
  endsequence

  a_change_starts: assert property (
    s_change_pending |=> (state == IOCS_START || state == IOCS_WAIT_FALL
                          || freq_select_out == $past(ctrl_sel)))
    else $error("select change did not start a switch");

  a_startup_waited: assert property (
    state == IOCS_START ##1 state == IOCS_WAIT_FALL
      |-> $past(cnt) == CNT_LAST && $past(rdy_sync[new_src]))
    else $error("handover began before start-up delay ended");

  a_old_fall_first: assert property (
    state == IOCS_WAIT_FALL ##1 state == IOCS_HOLD_LOW |-> $past(fall[cur_src]))
    else $error("hold entered without old clock falling edge");

  a_held_low: assert property (
    state == IOCS_HOLD_LOW ##1 state == IOCS_HOLD_LOW |-> !sys_clk_out)
    else $error("system clock not held low during handover");

  a_new_active: assert property (
    s_handover |-> cur_src == $past(new_src) && sys_clk_out && $past(rise[new_src]))
    else $error("new source not active on its rising edge");

  a_status_after: assert property (
    s_handover |=> status == onehot(cur_src) && state == IOCS_IDLE)
    else $error("status not updated after clock became active");

  a_status_idle: assert property (
    state == IOCS_IDLE |-> status == onehot(cur_src) && $countones(status) == 1)
    else $error("status does not show the active oscillator");

  a_same_source: assert property (
    s_change_pending and (src_of(ctrl_sel) == cur_src)
      |=> state == IOCS_IDLE && freq_select_out == $past(ctrl_sel))
    else $error("same source change was delayed");

  a_no_runt_low: assert property (
    s_handover |-> $past(new_fall_seen))
    else $error("handover without a full low phase of new clock");

  a_target_kept: assert property (
    s_handover |-> src_of(freq_select_out) == cur_src && freq_select_out == $past(tgt_sel))
    else $error("code in effect does not match the active source");

  a_new_enabled: assert property (
    state == IOCS_START |-> osc_enable[new_src])
    else $error("oscillator not started while waiting for it");

endmodule // iocs_clock_switch

/* rtl/iocs_pkg.sv */
// package for the internal oscillator clock switch: offsets, encodings, timing
package iocs_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [3:0] IOCS_CTRL_OFF = 4'h0;
  localparam logic [3:0] IOCS_STAT_OFF = 4'h4;

  // field positions
  localparam int IOCS_SEL_MSB   = 3;
  localparam int IOCS_STAT_LF   = 0;
  localparam int IOCS_STAT_MF   = 1;
  localparam int IOCS_STAT_HF   = 2;
  localparam int IOCS_STAT_BUSY = 4;

  // oscillator source indices
  localparam logic [1:0] IOCS_SRC_LF = 2'h0;
  localparam logic [1:0] IOCS_SRC_MF = 2'h1;
  localparam logic [1:0] IOCS_SRC_HF = 2'h2;

  // select codes at or above these come from the mid / high oscillator
  localparam logic [3:0] IOCS_SEL_MF_FIRST = 4'h1;
  localparam logic [3:0] IOCS_SEL_HF_FIRST = 4'h7;

  // values after reset: running from the low frequency oscillator
  localparam logic [3:0] IOCS_SEL_RESET  = 4'h0;
  localparam logic [2:0] IOCS_OSC_RESET  = 3'h1;

  // oscillator start-up delay
  localparam int IOCS_CLK_PERIOD_PS  = 8000;
  localparam int IOCS_STARTUP_NS     = 1000;
  localparam int IOCS_STARTUP_CYCLES =
    (IOCS_STARTUP_NS * 1000 + IOCS_CLK_PERIOD_PS - 1) / IOCS_CLK_PERIOD_PS;

  typedef enum logic [4:0] {
    IOCS_IDLE      = 5'b00001,
    IOCS_START     = 5'b00010,
    IOCS_WAIT_FALL = 5'b00100,
    IOCS_HOLD_LOW  = 5'b01000,
    IOCS_UPDATE    = 5'b10000
  } iocs_state_t;

endpackage

/* verif/iocs_osc_model.sv */
// behavioural model of the three internal oscillators
`timescale 1ns/10ps
module iocs_osc_model
#(
  parameter int STARTUP_NS = 200
)
(
  // run enables from the switch
  input  wire logic [2:0] osc_enable,
  // oscillator clocks and ready levels
  output logic      [2:0] osc_clk,
  output logic      [2:0] osc_ready
);
  for (genvar i = 0; i < 3; i++)
  begin : g_osc
    // half periods in ns: low, mid, high
    localparam int HALF_NS = (i == 0) ? 100 : ((i == 1) ? 48 : 28);
    logic c;
    logic r;
    assign osc_clk[i]   = c;
    assign osc_ready[i] = r;
    // a stopped oscillator stands low and is not ready
    initial
    begin
      c = 1'b0;
      r = 1'b0;
      forever
      begin
        if (osc_enable[i] === 1'b1)
        begin
          if (!r)
          begin
            #(STARTUP_NS);
            r = 1'b1;
          end
          #(HALF_NS);
          c = ~c;
        end
        else
        begin
          r = 1'b0;
          c = 1'b0;
          @(osc_enable[i]);
        end
      end
    end
  end
endmodule // iocs_osc_model

/* verif/iocs_clock_switch_test.sv */
// self-checking bench for the internal oscillator clock switch
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module iocs_clock_switch_test;
  import iocs_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [3:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  osc_clk;
  logic [2:0]  osc_rdy;
  logic [2:0]  osc_en;
  logic [3:0]  fsel;
  logic        sys_clk;
  logic [31:0] q;
  int          errors;
  int          samples_checked;
  int          n_edges;
  int          edges_before;
  realtime     last_t;
  realtime     min_ph;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  iocs_clock_switch #(.STARTUP_CYCLES(4)) u_iocs_clock_switch (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .osc_clk_in(osc_clk), .osc_ready_in(osc_rdy), .osc_enable(osc_en),
    .freq_select_out(fsel), .sys_clk_out(sys_clk));

  iocs_osc_model u_iocs_osc_model (
    .osc_enable(osc_en), .osc_clk(osc_clk), .osc_ready(osc_rdy));

  // shortest phase of the switched clock; first partial phase ignored
  always @(sys_clk)
  begin
    if (rst)
      n_edges = 0;
    else
    begin
      if (n_edges > 1 && $realtime - last_t < min_ph)
        min_ph = $realtime - last_t;
      n_edges++;
      last_t = $realtime;
    end
  end

  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge core_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do
      @(posedge core_clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // polls status until the switch reports done; the watchdog bounds it
  task automatic wait_idle;
    do
      xfer(1'b0, IOCS_STAT_OFF, 32'h0, 4'hF);
    while (q[IOCS_STAT_BUSY] !== 1'b0);
  endtask

  task automatic conclude;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #200000;
    errors++;
    conclude();
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    min_ph = 1.0e9;
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    xfer(1'b0, IOCS_STAT_OFF, 32'h0, 4'hF);
    `CHK("stat_reset", 32'h01, q)
    xfer(1'b0, 4'h8, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, q)
    `CHK("en_reset", 3'b001, osc_en)
    // low to a stopped high oscillator
    xfer(1'b1, IOCS_CTRL_OFF, 32'h7, 4'hF);
    xfer(1'b0, IOCS_STAT_OFF, 32'h0, 4'hF);
    `CHK("busy", 1'b1, q[IOCS_STAT_BUSY])
    repeat (10) @(posedge core_clk);
    `CHK("fsel_startup", 4'h0, fsel)
    `CHK("en_startup", 1'b1, osc_en[2])
    wait_idle();
    `CHK("stat_hf", 32'h04, q)
    `CHK("fsel_hf", 4'h7, fsel)
    `CHK("en_hf", 3'b100, osc_en)
    // same source: quick, never busy
    xfer(1'b1, IOCS_CTRL_OFF, 32'h9, 4'hF);
    repeat (3) @(posedge core_clk);
    `CHK("fsel_same", 4'h9, fsel)
    xfer(1'b0, IOCS_STAT_OFF, 32'h0, 4'hF);
    `CHK("stat_same", 32'h04, q)
    // byte lane 0 disabled: write dropped
    xfer(1'b1, IOCS_CTRL_OFF, 32'h0, 4'hE);
    xfer(1'b0, IOCS_CTRL_OFF, 32'h0, 4'hF);
    `CHK("ctrl_sel", 32'h9, q)
    // rewrite in mid-switch: the last value wins
    xfer(1'b1, IOCS_CTRL_OFF, 32'h0, 4'hF);
    xfer(1'b1, IOCS_CTRL_OFF, 32'h3, 4'hF);
    // switch to low idles one cycle before the follow-on switch; a poll may land there
    wait_idle();
    wait_idle();
    `CHK("stat_mf", 32'h02, q)
    `CHK("fsel_mf", 4'h3, fsel)
    xfer(1'b1, IOCS_CTRL_OFF, 32'h0, 4'hF);
    wait_idle();
    `CHK("stat_lf", 32'h01, q)
    `CHK("fsel_lf", 4'h0, fsel)
    `CHK("en_lf", 3'b001, osc_en)
    `CHK("min_phase", 1'b1, min_ph >= 24.0)
    // a stuck output would leave min_ph untouched
    edges_before = n_edges;
    repeat (40) @(posedge core_clk);
    `CHK("clk_runs", 1'b1, (n_edges - edges_before) >= 2)
    conclude();
  end
endmodule // iocs_clock_switch_test
